// ===== hw/idr_defs.vh
`ifndef IDR_DEFS_VH
`define IDR_DEFS_VH

`define IDR_ADDR_PREFIX 6'h26
`define IDR_BCAST_ADDR 8'h90
`define IDR_CTRL_ZERO_HI 7
`define IDR_CTRL_ZERO_LO 6
`define IDR_PM_HI_BIT 5
`define IDR_PM_LO_BIT 4
`define IDR_PM_NORMAL 2'h0
`define IDR_PM_1K 2'h1
`define IDR_PM_100K 2'h2
`define IDR_PM_HIZ 2'h3
`define IDR_DAC_RESET 12'h000
`define IDR_CLK_MHZ 200
`define IDR_RECOV_5V_NS 2500
`define IDR_RECOV_3V_NS 5000
`define IDR_RECOV_5V_CYC ((`IDR_RECOV_5V_NS * `IDR_CLK_MHZ + 999) / 1000)
`define IDR_RECOV_3V_CYC ((`IDR_RECOV_3V_NS * `IDR_CLK_MHZ + 999) / 1000)

`endif

// ===== hw/idr_sync.v
`timescale 1ns/1ps
module idr_sync (
    input wire core_clk_i,
    input wire rst_i,
    input wire d_i,
    output reg q_o
);
    reg meta;
    // Reset high: idle bus level
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            meta <= 1'b1;
            q_o <= 1'b1;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // idr_sync

// ===== hw/idr_receiver.v
`timescale 1ns/1ps
`include "idr_defs.vh"
module idr_receiver #(
    parameter RECOV_CYC = `IDR_RECOV_5V_CYC,
    parameter RCNT_W = 16
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    input wire addr_select_pin_i,
    output reg sda_o,
    output reg sda_oe_n_o,
    output reg [11:0] dac_code_o,
    output reg power_mode_sel_hi_o,
    output reg power_mode_sel_lo_o,
    output reg powered_down_o,
    output reg amp_connect_o,
    output reg res_1k_o,
    output reg res_100k_o,
    output reg linear_on_o,
    output reg out_valid_o,
    output reg addressed_o,
    output reg update_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_HIGH = 2'h2;
    localparam ST_LOW = 2'h3;

    wire scl_s;
    wire sda_s;
    reg scl_d;
    reg sda_d;
    reg [1:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [7:0] hi_byte;
    reg ack_drive;
    reg load_pend;
    reg sel_strap;
    reg [1:0] strap_wait;
    wire sel_s;
    reg [RCNT_W-1:0] rcnt;

    idr_sync u_sync_scl (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .d_i(scl_i),
        .q_o(scl_s)
    );
    idr_sync u_sync_sda (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .d_i(sda_i),
        .q_o(sda_s)
    );
    idr_sync u_sync_sel (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .d_i(addr_select_pin_i),
        .q_o(sel_s)
    );

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    // Line conditions only valid when clock steady high
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
    wire [7:0] byte_in = {shift[6:0], sda_s};
    wire addr_ok = (byte_in == `IDR_BCAST_ADDR) ||
        (byte_in[7:2] == `IDR_ADDR_PREFIX && byte_in[1] == sel_strap && !byte_in[0]);
    wire [1:0] mode_now = {power_mode_sel_hi_o, power_mode_sel_lo_o};

    // Strap caught once, after the synchroniser has flushed its reset value
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            strap_wait <= 2'h0;
            sel_strap <= 1'b0;
        end else if (strap_wait != 2'h3) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == 2'h2) begin
                sel_strap <= sel_s;
            end
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            hi_byte <= 8'h00;
            ack_drive <= 1'b0;
            load_pend <= 1'b0;
            dac_code_o <= `IDR_DAC_RESET;
            power_mode_sel_hi_o <= 1'b0;
            power_mode_sel_lo_o <= 1'b0;
            addressed_o <= 1'b0;
            update_o <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            update_o <= 1'b0;
            if (start_det) begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                ack_drive <= 1'b0;
                load_pend <= 1'b0;
                addressed_o <= 1'b0;
            end else if (stop_det) begin
                state <= ST_IDLE;
                bit_cnt <= 4'h0;
                ack_drive <= 1'b0;
                load_pend <= 1'b0;
                addressed_o <= 1'b0;
            end else if (state != ST_IDLE) begin
                // Sample on rise; data is stable through high phase
                if (scl_rise && bit_cnt < 4'h8) begin
                    shift <= byte_in;
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == 4'h7) begin
                        case (state)
                            ST_ADDR: begin
                                if (addr_ok) begin
                                    ack_drive <= 1'b1;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end
                            ST_HIGH: begin
                                hi_byte <= byte_in;
                                ack_drive <= 1'b1;
                            end
                            ST_LOW: begin
                                ack_drive <= 1'b1;
                                load_pend <= 1'b1;
                            end
                            default: begin
                                state <= ST_IDLE;
                            end
                        endcase
                    end
                end else if (scl_fall && bit_cnt == 4'ha) begin
                    // End of ack clock: release line, advance
                    ack_drive <= 1'b0;
                    bit_cnt <= 4'h0;
                    case (state)
                        ST_ADDR: begin
                            state <= ST_HIGH;
                            addressed_o <= 1'b1;
                        end
                        ST_HIGH: begin
                            state <= ST_LOW;
                        end
                        ST_LOW: begin
                            state <= ST_HIGH;
                            if (load_pend) begin
                                dac_code_o <= {hi_byte[3:0], shift};
                                power_mode_sel_hi_o <= hi_byte[`IDR_PM_HI_BIT];
                                power_mode_sel_lo_o <= hi_byte[`IDR_PM_LO_BIT];
                                update_o <= 1'b1;
                            end
                            load_pend <= 1'b0;
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end else if (scl_fall && bit_cnt == 4'h8) begin
                    bit_cnt <= 4'h9;
                end else if (scl_rise && bit_cnt == 4'h9) begin
                    bit_cnt <= 4'ha;
                end
            end
        end
    end

    // Ack only after the fall ending bit 8; pulling low while high would fake a start
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            sda_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
        end else begin
            sda_o <= 1'b0;
            sda_oe_n_o <= ~(ack_drive && (bit_cnt == 4'h9 || bit_cnt == 4'ha));
        end
    end

    // Output stage; stored code untouched by mode
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            powered_down_o <= 1'b0;
            amp_connect_o <= 1'b1;
            res_1k_o <= 1'b0;
            res_100k_o <= 1'b0;
            linear_on_o <= 1'b1;
            out_valid_o <= 1'b1;
            rcnt <= {RCNT_W{1'b0}};
        end else begin
            powered_down_o <= (mode_now != `IDR_PM_NORMAL);
            amp_connect_o <= (mode_now == `IDR_PM_NORMAL);
            res_1k_o <= (mode_now == `IDR_PM_1K);
            res_100k_o <= (mode_now == `IDR_PM_100K);
            linear_on_o <= (mode_now == `IDR_PM_NORMAL);
            if (mode_now != `IDR_PM_NORMAL) begin
                rcnt <= RECOV_CYC[RCNT_W-1:0];
                out_valid_o <= 1'b0;
            end else if (rcnt != {RCNT_W{1'b0}}) begin
                rcnt <= rcnt - {{(RCNT_W-1){1'b0}}, 1'b1};
                out_valid_o <= 1'b0;
            end else begin
                out_valid_o <= 1'b1;
            end
        end
    end
endmodule // idr_receiver

// ===== verif/idr_receiver_assertions.sv
`timescale 1ns/1ps
module idr_receiver_assertions (
    input wire core_clk_i,
    input wire rst_i,
    input wire sda_o,
    input wire sda_oe_n_o,
    input wire [11:0] dac_code_o,
    input wire power_mode_sel_hi_o,
    input wire power_mode_sel_lo_o,
    input wire powered_down_o,
    input wire amp_connect_o,
    input wire res_1k_o,
    input wire res_100k_o,
    input wire out_valid_o,
    input wire addressed_o,
    input wire update_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_ack_hold; !sda_oe_n_o [*8]; endsequence
    sequence s_recover; !out_valid_o [*8]; endsequence
    property p_ack_hold; $fell(sda_oe_n_o) |-> s_ack_hold; endproperty
    property p_ack_drv; !sda_oe_n_o |-> !sda_o; endproperty
    property p_code_src; $changed(dac_code_o) |-> update_o; endproperty
    property p_mode_src; $changed({power_mode_sel_hi_o, power_mode_sel_lo_o}) |-> update_o;
    endproperty
    property p_upd_pulse; update_o |=> !update_o; endproperty
    property p_upd_addr; update_o |-> addressed_o; endproperty
    property p_pd_off; powered_down_o |-> !amp_connect_o && !out_valid_o; endproperty
    property p_net; res_1k_o |-> !res_100k_o && !amp_connect_o; endproperty
    property p_recover; $fell(powered_down_o) |-> s_recover; endproperty
    property p_reset; disable iff (1'b0) rst_i |=> dac_code_o == 12'h000; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
    a_ack_drv: assert property (p_ack_drv) else $error("ack drives high");
    a_code_src: assert property (p_code_src) else $error("code moved without load");
    a_mode_src: assert property (p_mode_src) else $error("mode moved without load");
    a_upd_pulse: assert property (p_upd_pulse) else $error("load pulse too long");
    a_upd_addr: assert property (p_upd_addr) else $error("load while idle");
    a_pd_off: assert property (p_pd_off) else $error("amplifier on in power-down");
    a_net: assert property (p_net) else $error("two networks selected");
    a_recover: assert property (p_recover) else $error("valid too soon");
    a_reset: assert property (p_reset) else $error("code not cleared");
endmodule // idr_receiver_assertions

bind idr_receiver idr_receiver_assertions u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .dac_code_o(dac_code_o),
    .power_mode_sel_hi_o(power_mode_sel_hi_o), .power_mode_sel_lo_o(power_mode_sel_lo_o),
    .powered_down_o(powered_down_o), .amp_connect_o(amp_connect_o), .res_1k_o(res_1k_o),
    .res_100k_o(res_100k_o), .out_valid_o(out_valid_o), .addressed_o(addressed_o),
    .update_o(update_o));

// ===== verif/idr_master_model.sv
`timescale 1ns/1ps
module idr_master_model (
    input wire core_clk_i,
    input wire sda_i,
    output reg scl_o,
    output reg sda_o
);
    // Clock idles high between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task q;
        repeat (4) @(posedge core_clk_i);
    endtask
    task start;
        begin
            q;
            sda_o <= 1'b1;
            q;
            scl_o <= 1'b1;
            q;
            sda_o <= 1'b0;
            q;
            scl_o <= 1'b0;
        end
    endtask
    task stop;
        begin
            q;
            sda_o <= 1'b0;
            q;
            scl_o <= 1'b1;
            q;
            sda_o <= 1'b1;
            q;
        end
    endtask
    // Clock low with no start, so later bytes reach an unaddressed device
    task park;
        begin
            q;
            scl_o <= 1'b0;
        end
    endtask
    // Data moves only while clock low; ends on the ninth fall
    task tx(input [7:0] b, output ack);
        integer i;
        begin
            for (i = 7; i >= -1; i = i - 1) begin
                q;
                sda_o <= (i < 0) ? 1'b1 : b[i];
                q;
                scl_o <= 1'b1;
                q;
                ack = ~sda_i;
                q;
                scl_o <= 1'b0;
            end
        end
    endtask
endmodule // idr_master_model

// ===== verif/idr_receiver_test.sv
`timescale 1ns/1ps
module idr_receiver_test;
    reg core_clk_i, rst_i, sel, ack;
    reg [2:0] m;
    wire scl, msda, sda_o, oe_n, pmh, pml, pd, amp, r1k, r100k, lin, ov, adr, upd;
    wire [11:0] code;
    wire sda = msda & (oe_n | sda_o);
    integer errors, comparisons, cyc, w;
    idr_master_model u_idr_master_model (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl),
        .sda_o(msda));
    idr_receiver #(.RECOV_CYC(20)) u_idr_receiver (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .scl_i(scl), .sda_i(sda), .addr_select_pin_i(sel), .sda_o(sda_o), .sda_oe_n_o(oe_n),
        .dac_code_o(code), .power_mode_sel_hi_o(pmh), .power_mode_sel_lo_o(pml),
        .powered_down_o(pd), .amp_connect_o(amp), .res_1k_o(r1k), .res_100k_o(r100k),
        .linear_on_o(lin), .out_valid_o(ov), .addressed_o(adr), .update_o(upd));
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task send(input [7:0] b, input exp);
        begin
            u_idr_master_model.tx(b, ack);
            chk(ack, exp);
        end
    endtask
    task pair(input [7:0] hi, input [7:0] lo);
        begin
            send(hi, 1'b1);
            send(lo, 1'b1);
            w = 0;
            while (upd !== 1'b1 && w < 20) begin
                @(posedge core_clk_i);
                w = w + 1;
            end
            chk(upd, 1'b1);
            chk(adr, 1'b1);
            repeat (3) @(posedge core_clk_i);
        end
    endtask
    task t_basic;
        begin
            chk({ov, code}, 16'h1000);
            u_idr_master_model.start;
            send(8'h9a, 1'b1);
            pair(8'h0a, 8'hbc);
            chk(code, 16'h0abc);
            pair(8'h31, 8'h23);
            chk({pmh, pml, code}, 16'h3123);
            u_idr_master_model.stop;
            u_idr_master_model.park;
            send(8'h9a, 1'b0);
            u_idr_master_model.stop;
            chk(adr, 1'b0);
            $display("t_basic done");
        end
    endtask
    task t_refuse;
        begin
            u_idr_master_model.start;
            send(8'h98, 1'b0);
            chk(adr, 1'b0);
            send(8'h05, 1'b0);
            u_idr_master_model.start;
            send(8'h9b, 1'b0);
            u_idr_master_model.stop;
            chk(code, 16'h0123);
            $display("t_refuse done");
        end
    endtask
    task t_modes;
        begin
            u_idr_master_model.start;
            send(8'h90, 1'b1);
            send(8'h12, 1'b1);
            u_idr_master_model.start;
            send(8'h9a, 1'b1);
            chk(code, 16'h0123);
            for (m = 0; m < 4; m = m + 1) begin
                pair({2'b00, m[1:0], 4'h5}, 8'h66);
                chk({pd, amp, lin}, {m != 0, m == 0, m == 0});
                chk({r1k, r100k}, {m == 1, m == 2});
                chk(code, 16'h0566);
            end
            pair(8'h05, 8'h66);
            chk({ov, code}, 16'h0566);
            repeat (25) @(posedge core_clk_i);
            chk(ov, 1'b1);
            u_idr_master_model.stop;
            $display("t_modes done");
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    // Ceiling well above the few thousand cycles the tests need
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            conclude;
        end
    end
    initial begin
        errors = 0;
        comparisons = 0;
        cyc = 0;
        rst_i = 1'b1;
        sel = 1'b1;
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        t_basic;
        t_refuse;
        t_modes;
        conclude;
    end
endmodule // idr_receiver_test
